//--- hdl/sd_host_control_and_soft_reset.sv
// Host control and system control registers with self-clearing line soft resets.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Three-bit bus voltage select at bits 11:9; 5h 1.8V, 6h 3.0V, 7h 3.3V.
// - Host control bytes: wakeup, block gap, power 15:8, host control 7:0.
// - System control: resets 31:24, timeout 23:16, clock control 15:0.
// - Writing 1 to bit 26 or 25 starts that reset; bit self-clears when done.
// - Data-line reset resets data state machines in both clock domains.
// - Data-line reset clears buffer, data flags, gap controls and data status.
// - Data-line reset reinitialises bus-side handling and buffer management.
// - Command-line reset resets command state machines in both clock domains.
// - Command-line reset clears command inhibit, command complete, status handling.
// - Full reset bit 24 resets everything but the event mask and the reset-done event; self-clears.
module sd_host_control_and_soft_reset
	import sd_ctrl_pkg::*;
#(
	parameter int rst_cycles = rst_hold_cyc
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        card_clk_in,
	input  wire logic        cmd_issue,
	input  wire logic        cmd_end,
	input  wire logic        dat_start_rd,
	input  wire logic        dat_start_wr,
	input  wire logic        dat_block_end,
	input  wire logic        dat_last_end,
	input  wire logic [31:0] buf_wdata,
	input  wire logic        buf_wvalid,
	output logic [31:0]      data_buffer,
	output logic [2:0]       bus_voltage_select,
	output logic             card_clock_enable,
	output logic             internal_clock_enable,
	output logic [9:0]       clock_divider,
	output logic [3:0]       data_timeout_value,
	output logic             dat_fsm_rst,
	output logic             cmd_fsm_rst,
	output logic             full_fsm_rst,
	output logic             irq
);

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	function automatic logic is_reg(input logic [11:0] a);
		return a == host_control_off || a == system_control_off || a == event_status_off ||
			a == event_mask_off || a == line_state_off;
	endfunction

	logic wr_en;
	logic rd_en;
	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & penable & ~pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~is_reg(paddr);

	logic wr_hctl;
	logic wr_sctl;
	logic wr_mask;
	assign wr_hctl = wr_en && paddr == host_control_off;
	assign wr_sctl = wr_en && paddr == system_control_off;
	assign wr_mask = wr_en && paddr == event_mask_off;

	// ****************************************************************
	// Link clock edges
	// ****************************************************************
	logic link_lvl;
	logic link_rise;
	sd_link_sync u_sync (
		.pclk      (pclk),
		.presetn   (presetn),
		.link_in   (card_clk_in),
		.link_lvl  (link_lvl),
		.link_rise (link_rise)
	);

	// ****************************************************************
	// Soft reset sequencers
	// ****************************************************************
	// Each reset is held for a fixed number of clocks, which also covers a stopped card clock:
	// the card-side machines are cleared from this domain, so no card edge is needed to finish.
	rst_state_e dat_st_q;
	rst_state_e cmd_st_q;
	rst_state_e all_st_q;
	logic [15:0] dat_cnt_q;
	logic [15:0] cmd_cnt_q;
	logic [15:0] all_cnt_q;
	logic dat_req;
	logic cmd_req;
	logic all_req;
	assign all_req = wr_sctl & pstrb[3] & pwdata[full_rst_bit];
	assign dat_req = wr_sctl & pstrb[3] & pwdata[dat_rst_bit];
	assign cmd_req = wr_sctl & pstrb[3] & pwdata[cmd_rst_bit];

	localparam logic [15:0] rst_last = 16'(rst_cycles - 1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			all_st_q  <= rst_idle;
			all_cnt_q <= 16'h0000;
		end else begin
			case (all_st_q)
				rst_idle, rst_done: begin
					if (all_req) begin
						all_st_q  <= rst_run;
						all_cnt_q <= 16'h0000;
					end else all_st_q <= rst_idle;
				end
				rst_run: begin
					if (all_cnt_q == rst_last) all_st_q <= rst_done;
					else all_cnt_q <= all_cnt_q + 16'h0001;
				end
				default: all_st_q <= rst_idle;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dat_st_q  <= rst_idle;
			dat_cnt_q <= 16'h0000;
		end else begin
			case (dat_st_q)
				rst_idle, rst_done: begin
					if (dat_req) begin
						dat_st_q  <= rst_run;
						dat_cnt_q <= 16'h0000;
					end else dat_st_q <= rst_idle;
				end
				rst_run: begin
					if (dat_cnt_q == rst_last) dat_st_q <= rst_done;
					else dat_cnt_q <= dat_cnt_q + 16'h0001;
				end
				default: dat_st_q <= rst_idle;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_st_q  <= rst_idle;
			cmd_cnt_q <= 16'h0000;
		end else begin
			case (cmd_st_q)
				rst_idle, rst_done: begin
					if (cmd_req) begin
						cmd_st_q  <= rst_run;
						cmd_cnt_q <= 16'h0000;
					end else cmd_st_q <= rst_idle;
				end
				rst_run: begin
					if (cmd_cnt_q == rst_last) cmd_st_q <= rst_done;
					else cmd_cnt_q <= cmd_cnt_q + 16'h0001;
				end
				default: cmd_st_q <= rst_idle;
			endcase
		end
	end

	logic all_busy;
	logic dat_clr;
	logic cmd_clr;
	assign all_busy     = all_st_q == rst_run;
	assign dat_clr      = dat_st_q == rst_run || all_busy;
	assign cmd_clr      = cmd_st_q == rst_run || all_busy;
	assign dat_fsm_rst  = dat_clr;
	assign cmd_fsm_rst  = cmd_clr;
	assign full_fsm_rst = all_busy;

	// ****************************************************************
	// Control registers
	// ****************************************************************
	logic [2:0] bvs_q;
	logic       stop_gap_q;
	logic       cont_q;
	logic [3:0] tmo_q;
	logic [9:0] div_q;
	logic       card_clk_q;
	logic       int_clk_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bvs_q      <= host_control_rst[bvs_msb:bvs_lsb];
			stop_gap_q <= 1'b0;
			cont_q     <= 1'b0;
		end else if (all_busy) begin
			bvs_q      <= host_control_rst[bvs_msb:bvs_lsb];
			stop_gap_q <= 1'b0;
			cont_q     <= 1'b0;
		end else begin
			if (wr_hctl && pstrb[1]) bvs_q <= pwdata[bvs_msb:bvs_lsb];
			if (dat_clr) begin
				stop_gap_q <= 1'b0;
				cont_q     <= 1'b0;
			end else if (wr_hctl && pstrb[2]) begin
				stop_gap_q <= pwdata[stop_gap_bit];
				cont_q     <= pwdata[continue_bit] | (cont_q & ~dat_start_rd & ~dat_start_wr);
			end else if (dat_start_rd || dat_start_wr) begin
				cont_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmo_q      <= system_control_rst[tmo_msb:tmo_lsb];
			div_q      <= system_control_rst[div_msb:div_lsb];
			card_clk_q <= 1'b0;
			int_clk_q  <= 1'b0;
		end else if (all_busy) begin
			tmo_q      <= system_control_rst[tmo_msb:tmo_lsb];
			div_q      <= system_control_rst[div_msb:div_lsb];
			card_clk_q <= 1'b0;
			int_clk_q  <= 1'b0;
		end else if (wr_sctl) begin
			if (pstrb[2]) tmo_q <= pwdata[tmo_msb:tmo_lsb];
			if (pstrb[0]) begin
				card_clk_q <= pwdata[card_clk_en_bit];
				int_clk_q  <= pwdata[int_clk_en_bit];
			end
			if (pstrb[0] && pstrb[1]) div_q <= pwdata[div_msb:div_lsb];
		end
	end

	assign bus_voltage_select    = bvs_q;
	assign data_timeout_value    = tmo_q;
	assign clock_divider         = div_q;
	assign card_clock_enable     = card_clk_q;
	assign internal_clock_enable = int_clk_q;

	// ****************************************************************
	// Line state flags and data buffer
	// ****************************************************************
	logic cmd_busy_q;
	logic rd_act_q;
	logic wr_act_q;
	logic line_act_q;
	logic rd_rdy_q;
	logic wr_rdy_q;
	logic [31:0] buf_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) cmd_busy_q <= 1'b0;
		else if (cmd_clr) cmd_busy_q <= 1'b0;
		else if (cmd_issue) cmd_busy_q <= 1'b1;
		else if (cmd_end) cmd_busy_q <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_act_q   <= 1'b0;
			wr_act_q   <= 1'b0;
			line_act_q <= 1'b0;
			rd_rdy_q   <= 1'b0;
			wr_rdy_q   <= 1'b0;
			buf_q      <= 32'h0000_0000;
		end else if (dat_clr) begin
			rd_act_q   <= 1'b0;
			wr_act_q   <= 1'b0;
			line_act_q <= 1'b0;
			rd_rdy_q   <= 1'b0;
			wr_rdy_q   <= 1'b0;
			buf_q      <= 32'h0000_0000;
		end else begin
			if (dat_start_rd) rd_act_q <= 1'b1;
			else if (dat_last_end) rd_act_q <= 1'b0;
			if (dat_start_wr) wr_act_q <= 1'b1;
			else if (dat_last_end) wr_act_q <= 1'b0;
			if (dat_start_rd || dat_start_wr || (cont_q && link_rise)) line_act_q <= 1'b1;
			else if (dat_last_end || (stop_gap_q && dat_block_end)) line_act_q <= 1'b0;
			if (buf_wvalid) begin
				buf_q    <= buf_wdata;
				rd_rdy_q <= rd_act_q;
			end
			wr_rdy_q <= wr_act_q & ~buf_wvalid;
		end
	end

	logic dat_busy;
	assign dat_busy    = line_act_q | rd_act_q;
	assign data_buffer = buf_q;

	// ****************************************************************
	// Events and interrupt
	// ****************************************************************
	logic [ev_width-1:0] ev_q;
	logic [ev_width-1:0] mask_q;
	logic [ev_width-1:0] ev_set;
	logic dat_busy_q;
	logic rst_fin;
	logic rd_stat;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) dat_busy_q <= 1'b0;
		else dat_busy_q <= dat_busy;
	end

	assign rst_fin = (dat_st_q == rst_done) | (cmd_st_q == rst_done) | (all_st_q == rst_done);
	assign rd_stat = rd_en && paddr == event_status_off;

	always_comb begin
		ev_set = '0;
		ev_set[ev_cmd_done]  = cmd_end & cmd_busy_q;
		ev_set[ev_xfer_done] = dat_busy_q & ~dat_busy;
		ev_set[ev_gap]       = stop_gap_q & dat_block_end;
		ev_set[ev_wr_ready]  = wr_act_q & ~buf_wvalid & ~wr_rdy_q;
		ev_set[ev_rd_ready]  = rd_act_q & buf_wvalid;
		ev_set[ev_rst_done]  = rst_fin;
	end

	// A read clears only the bits it returned, so an event in its setup cycle is not lost.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) ev_q <= '0;
		else begin
			ev_q <= (rd_stat ? ev_q & ~prdata[ev_width-1:0] : ev_q) | ev_set;
			if (dat_clr) begin
				ev_q[ev_xfer_done] <= 1'b0;
				ev_q[ev_gap]       <= 1'b0;
				ev_q[ev_wr_ready]  <= 1'b0;
				ev_q[ev_rd_ready]  <= 1'b0;
			end
			if (cmd_clr) ev_q[ev_cmd_done] <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) mask_q <= '0;
		else if (wr_mask) mask_q <= pwdata[ev_width-1:0];
	end

	assign irq = |(ev_q & mask_q);

	// ****************************************************************
	// Read data
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite) begin
			prdata <= 32'h0000_0000;
			if (paddr == host_control_off) begin
				prdata[bvs_msb:bvs_lsb] <= bvs_q;
				prdata[stop_gap_bit]    <= stop_gap_q;
				prdata[continue_bit]    <= cont_q;
			end else if (paddr == system_control_off) begin
				prdata[dat_rst_bit]         <= dat_st_q == rst_run;
				prdata[cmd_rst_bit]         <= cmd_st_q == rst_run;
				prdata[full_rst_bit]        <= all_busy;
				prdata[tmo_msb:tmo_lsb]     <= tmo_q;
				prdata[div_msb:div_lsb]     <= div_q;
				prdata[card_clk_en_bit]     <= card_clk_q;
				prdata[int_clk_st_bit]      <= int_clk_q;
				prdata[int_clk_en_bit]      <= int_clk_q;
			end else if (paddr == event_status_off) begin
				prdata[ev_width-1:0] <= ev_q;
			end else if (paddr == event_mask_off) begin
				prdata[ev_width-1:0] <= mask_q;
			end else if (paddr == line_state_off) begin
				prdata[0]  <= cmd_busy_q;
				prdata[1]  <= dat_busy;
				prdata[2]  <= line_act_q;
				prdata[8]  <= wr_act_q;
				prdata[9]  <= rd_act_q;
				prdata[10] <= wr_rdy_q;
				prdata[11] <= rd_rdy_q;
				prdata[12] <= link_lvl;
			end
		end
	end

endmodule // sd_host_control_and_soft_reset
`default_nettype wire

//--- inc/sd_ctrl_pkg.sv
// Package of register offsets, field positions and timing counts for the SD host control bank.
package sd_ctrl_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [11:0] host_control_off   = 12'h228;
	localparam logic [11:0] system_control_off = 12'h22c;
	localparam logic [11:0] event_status_off   = 12'h230;
	localparam logic [11:0] event_mask_off     = 12'h234;
	localparam logic [11:0] line_state_off     = 12'h238;
	localparam logic [31:0] host_control_rst   = 32'h0000_0000;
	localparam logic [31:0] system_control_rst = 32'h0000_0000;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int bvs_lsb         = 9;
	localparam int bvs_msb         = 11;
	localparam int stop_gap_bit    = 16;
	localparam int continue_bit    = 17;
	localparam int full_rst_bit    = 24;
	localparam int cmd_rst_bit     = 25;
	localparam int dat_rst_bit     = 26;
	localparam int tmo_lsb         = 16;
	localparam int tmo_msb         = 19;
	localparam int div_lsb         = 6;
	localparam int div_msb         = 15;
	localparam int card_clk_en_bit = 2;
	localparam int int_clk_st_bit  = 1;
	localparam int int_clk_en_bit  = 0;

	localparam logic [2:0] bvs_1v8 = 3'h5;
	localparam logic [2:0] bvs_3v0 = 3'h6;
	localparam logic [2:0] bvs_3v3 = 3'h7;

	// Event status bit positions.
	localparam int ev_cmd_done  = 0;
	localparam int ev_xfer_done = 1;
	localparam int ev_gap       = 2;
	localparam int ev_wr_ready  = 4;
	localparam int ev_rd_ready  = 5;
	localparam int ev_rst_done  = 8;
	localparam int ev_width     = 9;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int pclk_mhz       = 250;
	localparam int rst_hold_ns    = 64;
	localparam int rst_hold_cyc   = (rst_hold_ns * pclk_mhz + 999) / 1000;

	typedef enum logic [1:0] {rst_idle, rst_run, rst_done} rst_state_e;

endpackage

//--- hdl/sd_link_sync.sv
// Two-flop synchroniser and edge finder for the card-side link clock.
`timescale 1ns/1ps
`default_nettype none
module sd_link_sync (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic link_in,
	output logic      link_lvl,
	output logic      link_rise
);
	logic meta_q;
	logic sync_q;
	logic last_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= link_in;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign link_lvl  = sync_q;
	assign link_rise = sync_q & ~last_q;
endmodule // sd_link_sync
`default_nettype wire

//--- sim/sd_card_model.sv
// Card-side model that makes the link clock only inside a frame.
`timescale 1ns/1ps
`default_nettype none
module sd_card_model (
	input  wire logic run,
	output logic      card_clk
);
	// The clock rests low between frames; the odd start keeps it out of phase with pclk.
	initial begin
		card_clk = 1'b0;
		#3.3;
		forever begin
			#16;
			card_clk = run ? ~card_clk : 1'b0;
		end
	end
endmodule // sd_card_model
`default_nettype wire

//--- sim/sd_ctrl_sva.sv
// Assertion checker for the SD host control bank.
`timescale 1ns/1ps
`default_nettype none
module sd_ctrl_sva
	import sd_ctrl_pkg::*;
#(
	parameter int rst_cycles = rst_hold_cyc
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic [31:0] data_buffer,
	input wire logic [2:0]  bus_voltage_select,
	input wire logic [9:0]  clock_divider,
	input wire logic [3:0]  data_timeout_value,
	input wire logic        dat_fsm_rst,
	input wire logic        cmd_fsm_rst,
	input wire logic        full_fsm_rst
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic       acc;
	logic       sys_wr;
	logic [7:0] run_q;
	assign acc = psel && penable;
	assign sys_wr = acc && pwrite && paddr == system_control_off && pstrb[3];
	// Counts how long a data reset runs, so a bit that never clears is caught.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			run_q <= 8'h0;
		else
			run_q <= dat_fsm_rst ? run_q + 8'h1 : 8'h0;
	end
	property p_dat_go; sys_wr && pwdata[dat_rst_bit] |=> dat_fsm_rst; endproperty
	a_dat_go: assert property (p_dat_go) else $error("data reset did not start");
	property p_cmd_go; sys_wr && pwdata[cmd_rst_bit] |=> cmd_fsm_rst; endproperty
	a_cmd_go: assert property (p_cmd_go) else $error("command reset did not start");
	property p_full_go; sys_wr && pwdata[full_rst_bit] |=> full_fsm_rst; endproperty
	a_full_go: assert property (p_full_go) else $error("full reset did not start");
	property p_dat_end; int'(run_q) <= 2 * rst_cycles + 4; endproperty
	a_dat_end: assert property (p_dat_end) else $error("data reset never ends");
	property p_dat_buf; dat_fsm_rst |=> data_buffer == 32'h0; endproperty
	a_dat_buf: assert property (p_dat_buf) else $error("data buffer kept through reset");
	property p_full_clr; full_fsm_rst |=> bus_voltage_select == 3'h0 && clock_divider == 10'h0; endproperty
	a_full_clr: assert property (p_full_clr) else $error("full reset left controls set");
	property p_bvs_wr;
		acc && pwrite && paddr == host_control_off && pstrb[1] && !full_fsm_rst
			|=> bus_voltage_select == $past(pwdata[11:9]);
	endproperty
	a_bvs_wr: assert property (p_bvs_wr) else $error("voltage select not stored");
	property p_bvs_hold;
		!$stable(bus_voltage_select) |-> $past(acc && paddr == host_control_off) || $past(full_fsm_rst) || $past(sys_wr);
	endproperty
	a_bvs_hold: assert property (p_bvs_hold) else $error("voltage select changed unasked");
	property p_hc_rd;
		acc && !pwrite && paddr == host_control_off && !full_fsm_rst && !$past(full_fsm_rst)
			|-> prdata[31:18] == 14'h0 && prdata[15:0] == {4'h0, bus_voltage_select, 9'h0};
	endproperty
	a_hc_rd: assert property (p_hc_rd) else $error("host control read wrong");
	property p_sc_rd;
		acc && !pwrite && paddr == system_control_off && !full_fsm_rst && !$past(full_fsm_rst)
			|-> prdata[23:20] == 4'h0 && prdata[19:16] == data_timeout_value && prdata[15:6] == clock_divider;
	endproperty
	a_sc_rd: assert property (p_sc_rd) else $error("system control read wrong");
	c_dat: cover property ($fell(dat_fsm_rst));
	c_cmd: cover property ($fell(cmd_fsm_rst));
	c_full: cover property ($fell(full_fsm_rst));
endmodule // sd_ctrl_sva
bind sd_host_control_and_soft_reset sd_ctrl_sva #(.rst_cycles(rst_cycles)) u_sva (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .data_buffer(data_buffer),
	.bus_voltage_select(bus_voltage_select), .clock_divider(clock_divider),
	.data_timeout_value(data_timeout_value), .dat_fsm_rst(dat_fsm_rst), .cmd_fsm_rst(cmd_fsm_rst),
	.full_fsm_rst(full_fsm_rst)
);
`default_nettype wire

//--- sim/tb_sd_host_control_and_soft_reset.sv
// Self-checking bench for the SD host control bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_fail++; \
	$display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_sd_host_control_and_soft_reset;
	import sd_ctrl_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, run, card_clk, rerr;
	logic        card_clock_enable, internal_clock_enable, dat_fsm_rst, cmd_fsm_rst, full_fsm_rst;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat, v, buf_wdata, data_buffer;
	logic [3:0]  pstrb, data_timeout_value;
	logic [6:0]  pin_q;
	logic [2:0]  bus_voltage_select;
	logic [9:0]  clock_divider;
	int          n_fail, n_compared;
	sd_card_model card (.run(run), .card_clk(card_clk));
	sd_host_control_and_soft_reset #(.rst_cycles(2)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.card_clk_in(card_clk), .cmd_issue(pin_q[0]), .cmd_end(pin_q[1]), .dat_start_rd(pin_q[2]),
		.dat_start_wr(pin_q[3]), .dat_block_end(pin_q[4]), .dat_last_end(pin_q[5]), .buf_wdata(buf_wdata),
		.buf_wvalid(pin_q[6]), .data_buffer(data_buffer), .bus_voltage_select(bus_voltage_select),
		.card_clock_enable(card_clock_enable), .internal_clock_enable(internal_clock_enable),
		.clock_divider(clock_divider), .data_timeout_value(data_timeout_value), .dat_fsm_rst(dat_fsm_rst),
		.cmd_fsm_rst(cmd_fsm_rst), .full_fsm_rst(full_fsm_rst), .irq(irq)
	);
	task automatic results();
		if (n_fail == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			if (++n > 50) begin
				n_fail++;
				results();
			end
			@(posedge pclk);
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hf);
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0, 4'hf);
		v = rdat;
	endtask
	task automatic pulse(input int i);
		@(posedge pclk);
		pin_q[i] <= 1'b1;
		@(posedge pclk);
		pin_q[i] <= 1'b0;
	endtask
	// A reset bit must read back as zero before the line is used again.
	task automatic poll(input int b);
		int n;
		n = 0;
		rd(system_control_off);
		`CHK("reset bit set", 1'b1, v[b])
		while (v[b] !== 1'b0) begin
			if (++n > 100) begin
				n_fail++;
				results();
			end
			rd(system_control_off);
		end
	endtask
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, pstrb, pin_q, run} = '0;
		buf_wdata = 32'ha5a5_5a5a;
		n_fail = 0;
		n_compared = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(host_control_off);
		`CHK("hctl reset", host_control_rst, v)
		rd(system_control_off);
		`CHK("sysctl reset", system_control_rst, v)
		for (int c = 5; c < 8; c++) begin
			wr(host_control_off, 32'(c) << 9);
			rd(host_control_off);
			`CHK("bvs", 32'(c) << 9, v)
			`CHK("bvs pin", 3'(c), bus_voltage_select)
		end
		apb(1'b1, host_control_off, 32'h0, 4'hd);
		@(posedge pclk);
		`CHK("bvs lane", 3'h7, bus_voltage_select)
		wr(host_control_off, 32'hfffc_ffff);
		rd(host_control_off);
		`CHK("hctl layout", 32'h0000_0e00, v)
		wr(host_control_off, {20'h0, bvs_1v8, 9'h0});
		wr(system_control_off, 32'h00ff_fffd);
		rd(system_control_off);
		`CHK("sysctl layout", 32'h000f_ffc7, v)
		`CHK("clk pins", 16'hffff, {clock_divider, data_timeout_value, card_clock_enable, internal_clock_enable})
		wr(event_mask_off, 32'h100);
		rd(event_status_off);
		pulse(1);
		pulse(0);
		rd(line_state_off);
		`CHK("cmd inhibit", 1'b1, v[0])
		wr(system_control_off, 32'h020f_ffc5);
		poll(cmd_rst_bit);
		repeat (2) @(posedge pclk);
		`CHK("irq", 1'b1, irq)
		rd(line_state_off);
		`CHK("cmd inhibit", 1'b0, v[0])
		rd(event_status_off);
		`CHK("cmd status", 9'h100, v[8:0])
		@(posedge pclk);
		`CHK("irq", 1'b0, irq)
		rd(system_control_off);
		`CHK("sysctl kept", 32'h000f_ffc7, v)
		run <= 1'b1;
		pulse(6);
		@(posedge pclk);
		`CHK("buffer", buf_wdata, data_buffer)
		pulse(2);
		wr(host_control_off, 32'h0003_0a00);
		repeat (30) @(posedge pclk);
		rd(line_state_off);
		`CHK("line active", 1'b1, v[2])
		run <= 1'b0;
		wr(event_mask_off, 32'h0);
		wr(system_control_off, 32'h040f_ffc5);
		poll(dat_rst_bit);
		`CHK("buffer", 32'h0, data_buffer)
		`CHK("irq masked", 1'b0, irq)
		rd(line_state_off);
		`CHK("line flags", 12'h0, v[11:0])
		rd(host_control_off);
		`CHK("gap controls", 32'h0000_0a00, v)
		rd(event_status_off);
		`CHK("data status", 9'h100, v[8:0])
		wr(system_control_off, 32'h010f_ffc5);
		poll(full_rst_bit);
		rd(host_control_off);
		`CHK("full hctl", 32'h0, v)
		rd(system_control_off);
		`CHK("full sysctl", 32'h0, v)
		rd(12'h300);
		`CHK("unmapped err", 1'b1, rerr)
		`CHK("unmapped data", 32'h0, v)
		results();
	end
endmodule // tb_sd_host_control_and_soft_reset
`default_nettype wire
